/* rtl/spi_frame_pkg.sv */
package spi_frame_pkg;
  // ************************************************************
  // Local register port map
  // ************************************************************
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h01;
  localparam logic [7:0] ADDR_STATUS_UP = 8'h02;
  localparam logic [7:0] ADDR_STATUS_LO = 8'h03;
  localparam logic [7:0] ADDR_FAULT_CLR = 8'h04;
  localparam int SETUP_WSIZE_BIT = 0;
  localparam int SETUP_RDY_SRC_BIT = 1;
  localparam int SETUP_EN_CUR_A_BIT = 2;
  localparam int SETUP_EN_CUR_B_BIT = 3;
  localparam int SETUP_EN_VOLT_A_BIT = 4;
  localparam int SETUP_EN_VOLT_B_BIT = 5;
  localparam logic [15:0] SETUP_RESET = 16'h003c;
  localparam int CTRL_START_A_BIT = 0;
  localparam int CTRL_START_B_BIT = 1;
  // ************************************************************
  // Frame layout and checksum
  // ************************************************************
  localparam logic [5:0] WORD_BITS_SHORT = 6'h18;
  localparam logic [5:0] WORD_BITS_LONG = 6'h20;
  localparam logic [5:0] STD_FRAME_WORDS = 6'h06;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK = 16'h0655;
  localparam logic [2:0] OP_REGISTER_WRITE_CMD = 3'h3;
  localparam logic [2:0] OP_REGISTER_READ_CMD = 3'h5;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int LINK_TIMEOUT_NS = 1000000;
  localparam int TIMEOUT_CYCLES_DEF = (LINK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FRAME = 2'b10} frame_state_t;
  typedef enum logic [3:0] {
    RESP_NULL = 4'h0, RESP_RESET = 4'h1, RESP_LOCK = 4'h2,
    RESP_UNLOCK = 4'h3, RESP_REGISTER_WRITE_CMD = 4'h4, RESP_REGISTER_READ_CMD = 4'h5
  } resp_t;
endpackage

/* rtl/crc_if.sv */
`timescale 1ns/10ps
interface crc_if;
  logic seed;
  logic shift;
  logic din;
  logic [15:0] value;
  modport engine(input seed, input shift, input din, output value);
  modport user(output seed, output shift, output din, input value);
endinterface

/* rtl/crc16_serial.sv */
`timescale 1ns/10ps
module crc16_serial import spi_frame_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Checksum engine
  crc_if.engine c
);
  typedef struct packed {
    logic [15:0] crc;
  } crc_state_t;
  crc_state_t s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (!reset_n || c.seed) begin
      s_nxt.crc = CRC_SEED;
    end else if (c.shift) begin
      s_nxt.crc = {s_r.crc[14:0], 1'b0} ^ ((s_r.crc[15] ^ c.din) ? CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  assign c.value = s_r.crc;
endmodule

/* rtl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] m1;
    logic [W-1:0] m2;
  } sync_state_t;
  sync_state_t s_r, s_nxt;

  always_comb begin
    s_nxt.m1 = d;
    s_nxt.m2 = s_r.m1;
    if (!reset_n) begin
      s_nxt.m1 = RESET_VAL;
      s_nxt.m2 = RESET_VAL;
    end
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  assign q = s_r.m2;
endmodule

/* rtl/spi_frame_peripheral_interface.sv */
// What this block does
// R1: Mode 1: clock idles low, drive on rising edges, sample on falling edges.
// R2: Select high: ignore serial activity, data output released.
// R3: Select rising edge resets the interface and drops partial frames.
// R4: Select falling edge: data output driven low.
// R5: After last bit, output holds it; extra clock pulses drive it low.
// R6: Ready flag falls on new results of the selected current converter.
// R7: Voltage converter drives the flag when its current converter is off.
// R8: Ready flag low in reset, high once the device accepts traffic.
// R9: Both start bits in one write start both converters together.
// R10: Frame runs from select falling edge to next rising edge.
// R11: Input starts with command and checksum; output starts with status.
// R12: Plain commands use six-word frames with four converter results.
// R13: Writes of more than three registers lengthen the frame.
// R14: A register read is answered next frame with status and register words.
// R15: Word size 24 or 32 bits; content MSB-aligned, zero-filled.
// R16: Content widths: 16-bit input words, 24-bit output words, 16-bit checksum.
// R17: Status is status_upper_reg[15:0] joined with status_lower_reg[15:8].
// R18: Link fault flags report the previous frame, then clear.
// R19: Other status flags are sampled at frame start.
// R20: Device fault flags latch low until the host clears them.
// R21: Command response names the command executed last frame.
// R22: Counters belong to the data sent in the current frame.
// R23: Every checksum starts from all ones.
// R24: Output checksum covers all earlier output words, padding included.
// R25: Words shift most significant bit first.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module spi_frame_peripheral_interface import spi_frame_pkg::*; #(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic sclk_pin,
  input wire logic chip_select_low,
  input wire logic sdi_pin,
  output logic sdo_out,
  output logic sdo_oe_n,
  output logic data_ready_flag_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Converters
  input wire logic cur_a_done,
  input wire logic cur_b_done,
  input wire logic volt_a_done,
  input wire logic volt_b_done,
  input wire logic [23:0] cur_a_data,
  input wire logic [23:0] cur_b_data,
  input wire logic [23:0] volt_a_data,
  input wire logic [23:0] volt_b_data,
  output logic conv_start_a,
  output logic conv_start_b,
  // Device faults
  input wire logic [2:0] dev_fault_n
);
  typedef struct packed {
    frame_state_t st;
    logic sclk_d;
    logic cs_d;
    logic wsel;
    logic [5:0] tx_bit;
    logic [5:0] tx_word;
    logic [31:0] tx_sh;
    logic [5:0] rx_bit;
    logic [5:0] rx_word;
    logic [31:0] rx_sh;
    logic [15:0] cmd;
    logic cmd_ok;
    logic data_ok;
    logic [7:0][15:0] wr_buf;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic [4:0] rd_n;
    logic fr_rd;
    logic [7:0] fr_rd_addr;
    logic [4:0] fr_rd_n;
    logic [23:0] snap_status;
    logic [3:0][23:0] snap_data;
    logic f_crc_n;
    logic f_to_n;
    logic f_cnt_n;
    logic f_acc_n;
    logic [17:0] to_cnt;
    logic timed_out;
    logic [2:0] dev_lat_n;
    logic locked;
    resp_t cmd_resp;
    logic [3:0] cnt_a;
    logic [3:0] cnt_b;
    logic [15:0] setup;
    logic start_a;
    logic start_b;
    logic drdy_n;
    logic ready;
    logic relow;
    logic sdo;
    logic oe_n;
    logic [15:0] rd_data;
  } state_t;

  state_t s_r, s_nxt;
  logic [2:0] pins_s;
  logic sclk_s, cs_s, sdi_s;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic is_register_write_cmd, done_sel, cnt_bad, crc_bad, exec, wr_bad;
  logic [5:0] wbits, frame_len, in_len, resp_len;
  logic [31:0] out_word, tx_word_v, rx_new;
  logic [15:0] rx_content;
  logic [7:0] wa;

  crc_if ci ();
  crc_if co ();

  // ************************************************************
  // Pin synchronisers and checksum engines
  // ************************************************************
  pin_sync #(.W(3), .RESET_VAL(3'h2)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d({sclk_pin, chip_select_low, sdi_pin}),
    .q(pins_s)
  );

  crc16_serial u_crc_in (.core_clk(core_clk), .reset_n(reset_n), .c(ci.engine));
  crc16_serial u_crc_out (.core_clk(core_clk), .reset_n(reset_n), .c(co.engine));

  assign sclk_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign sdi_s = pins_s[0];
  assign sclk_rise = (s_r.st == ST_FRAME) && sclk_s && !s_r.sclk_d; // R1
  assign sclk_fall = (s_r.st == ST_FRAME) && !sclk_s && s_r.sclk_d; // R1
  assign cs_fall = (s_r.st == ST_IDLE) && !cs_s && s_r.cs_d; // R10
  assign cs_rise = (s_r.st == ST_FRAME) && cs_s; // R10

  // ************************************************************
  // Register views
  // ************************************************************
  function automatic logic [15:0] status_upper(input state_t s);
    return {s.f_crc_n, s.f_to_n, s.f_cnt_n, s.f_acc_n, s.locked, s.dev_lat_n, s.cnt_a, s.cnt_b};
  endfunction

  function automatic logic [15:0] read_reg(input logic [7:0] a, input state_t s);
    case (a)
      ADDR_SETUP: return s.setup;
      ADDR_STATUS_UP: return status_upper(s);
      ADDR_STATUS_LO: return {s.cmd_resp, 12'h000}; // R21
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic writable(input logic [7:0] a);
    return (a == ADDR_SETUP) || (a == ADDR_CONV_CTRL) || (a == ADDR_FAULT_CLR);
  endfunction

  function automatic state_t apply_write(input state_t x, input logic [7:0] a, input logic [15:0] d);
    state_t y;
    y = x;
    case (a)
      ADDR_SETUP: y.setup = d;
      ADDR_CONV_CTRL: begin
        y.start_a = d[CTRL_START_A_BIT]; // R9
        y.start_b = d[CTRL_START_B_BIT]; // R9
      end
      ADDR_FAULT_CLR: y.dev_lat_n = x.dev_lat_n | d[2:0];
      default: y = x;
    endcase
    return y;
  endfunction

  // ************************************************************
  // Frame length and output word
  // ************************************************************
  always_comb begin
    wbits = s_r.wsel ? WORD_BITS_LONG : WORD_BITS_SHORT; // R15
    is_register_write_cmd = (s_r.rx_word != 6'h00) && (s_r.cmd[15:13] == OP_REGISTER_WRITE_CMD);
    in_len = is_register_write_cmd ? 6'({3'h0, s_r.cmd[2:0]}) + 6'h04 : 6'h00; // R13
    resp_len = s_r.fr_rd ? 6'({1'b0, s_r.fr_rd_n}) + 6'h03 : STD_FRAME_WORDS; // R12 R14
    frame_len = (in_len > resp_len) ? in_len : resp_len;
    wa = s_r.fr_rd_addr + 8'(s_r.tx_word - 6'h01);
    if (s_r.tx_word == 6'h00) begin
      out_word = {s_r.snap_status, 8'h00}; // R11
    end else if (s_r.tx_word == frame_len - 6'h01) begin
      out_word = {co.value, 16'h0000}; // R24
    end else if (s_r.fr_rd) begin
      out_word = {read_reg(wa, s_r), wa, 8'h00}; // R14 R16
    end else if (s_r.tx_word <= 6'h04) begin
      out_word = {s_r.snap_data[2'(s_r.tx_word - 6'h01)], 8'h00}; // R12
    end else begin
      out_word = 32'h00000000;
    end
    tx_word_v = (s_r.tx_bit == 6'h00) ? out_word : s_r.tx_sh;
    rx_new = {s_r.rx_sh[30:0], sdi_s};
    rx_content = s_r.wsel ? rx_new[31:16] : rx_new[23:8]; // R15
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_d = sclk_s;
    s_nxt.cs_d = cs_s;
    s_nxt.start_a = 1'b0;
    s_nxt.start_b = 1'b0;
    s_nxt.rd_data = reg_rd ? read_reg(reg_addr, s_r) : 16'h0000;
    ci.seed = 1'b0;
    ci.shift = 1'b0;
    ci.din = sdi_s;
    co.seed = 1'b0;
    co.shift = 1'b0;
    co.din = tx_word_v[31];
    cnt_bad = (s_r.rx_bit != 6'h00) || (s_r.rx_word != frame_len);
    crc_bad = !s_r.cmd_ok || (is_register_write_cmd && !s_r.data_ok);
    exec = !cnt_bad && !crc_bad && !s_r.timed_out;
    wr_bad = s_r.locked;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= s_r.cmd[2:0] && !writable(s_r.cmd[12:5] + 8'(i))) begin
        wr_bad = 1'b1;
      end
    end
    if (reg_wr) begin
      s_nxt = apply_write(s_nxt, reg_addr, reg_wdata);
    end
    if (cur_a_done) begin
      s_nxt.cnt_a = s_r.cnt_a + 4'h1;
    end
    if (cur_b_done) begin
      s_nxt.cnt_b = s_r.cnt_b + 4'h1;
    end
    case (s_r.st)
      ST_IDLE: begin
        if (cs_fall) begin
          s_nxt.st = ST_FRAME;
          s_nxt.oe_n = 1'b0; // R4
          s_nxt.sdo = 1'b0; // R4
          s_nxt.wsel = s_r.setup[SETUP_WSIZE_BIT];
          s_nxt.snap_status = {status_upper(s_r), s_r.cmd_resp, 4'h0}; // R17 R19 R21 R22
          s_nxt.snap_data = {volt_b_data, volt_a_data, cur_b_data, cur_a_data}; // R22
          s_nxt.f_crc_n = 1'b1; // R18
          s_nxt.f_to_n = 1'b1; // R18
          s_nxt.f_cnt_n = 1'b1; // R18
          s_nxt.f_acc_n = 1'b1; // R18
          s_nxt.fr_rd = s_r.rd_pend; // R14
          s_nxt.fr_rd_addr = s_r.rd_addr;
          s_nxt.fr_rd_n = s_r.rd_n;
          s_nxt.rd_pend = 1'b0;
          s_nxt.cmd = 16'h0000;
          s_nxt.cmd_ok = 1'b0;
          s_nxt.data_ok = 1'b0;
          s_nxt.to_cnt = 18'h00000;
          s_nxt.timed_out = 1'b0;
          ci.seed = 1'b1; // R23
          co.seed = 1'b1; // R23
        end
      end
      ST_FRAME: begin
        if (cs_rise) begin
          s_nxt.st = ST_IDLE; // R3
          s_nxt.oe_n = 1'b1; // R2
          s_nxt.sdo = 1'b0;
          s_nxt.tx_bit = 6'h00; // R3
          s_nxt.tx_word = 6'h00;
          s_nxt.rx_bit = 6'h00;
          s_nxt.rx_word = 6'h00;
          s_nxt.fr_rd = 1'b0;
          s_nxt.f_cnt_n = !cnt_bad; // R18
          s_nxt.f_crc_n = !crc_bad; // R18
          s_nxt.f_to_n = !s_r.timed_out; // R18
          s_nxt.cmd_resp = RESP_NULL;
          if (exec) begin
            if (s_r.cmd == CMD_RESET && !s_r.locked) begin
              s_nxt.setup = SETUP_RESET;
              s_nxt.dev_lat_n = 3'h7;
              s_nxt.ready = 1'b0;
              s_nxt.cmd_resp = RESP_RESET;
            end else if (s_r.cmd == CMD_LOCK && !s_r.locked) begin
              s_nxt.locked = 1'b1;
              s_nxt.cmd_resp = RESP_LOCK;
            end else if (s_r.cmd == CMD_UNLOCK) begin
              s_nxt.locked = 1'b0;
              s_nxt.cmd_resp = RESP_UNLOCK;
            end else if (s_r.cmd[15:13] == OP_REGISTER_READ_CMD) begin
              s_nxt.rd_pend = 1'b1; // R14
              s_nxt.rd_addr = s_r.cmd[12:5];
              s_nxt.rd_n = s_r.cmd[4:0];
              s_nxt.cmd_resp = RESP_REGISTER_READ_CMD;
            end else if (s_r.cmd[15:13] == OP_REGISTER_WRITE_CMD) begin
              if (wr_bad) begin
                s_nxt.f_acc_n = 1'b0;
              end else begin
                for (int i = 0; i < 8; i++) begin
                  if (3'(i) <= s_r.cmd[2:0]) begin
                    s_nxt = apply_write(s_nxt, s_r.cmd[12:5] + 8'(i), s_r.wr_buf[i]);
                  end
                end
                s_nxt.cmd_resp = RESP_REGISTER_WRITE_CMD;
              end
            end
          end
        end else begin
          if (sclk_rise || sclk_fall) begin
            s_nxt.to_cnt = 18'h00000;
          end else if (s_r.to_cnt == 18'(TIMEOUT_CYCLES - 1)) begin
            s_nxt.timed_out = 1'b1;
          end else begin
            s_nxt.to_cnt = s_r.to_cnt + 18'h00001;
          end
          if (sclk_rise) begin
            if (s_r.tx_word < frame_len) begin
              s_nxt.sdo = tx_word_v[31]; // R1 R25
              s_nxt.tx_sh = {tx_word_v[30:0], 1'b0};
              co.shift = (s_r.tx_word != frame_len - 6'h01); // R24
              if (s_r.tx_bit == wbits - 6'h01) begin
                s_nxt.tx_bit = 6'h00;
                s_nxt.tx_word = s_r.tx_word + 6'h01;
              end else begin
                s_nxt.tx_bit = s_r.tx_bit + 6'h01;
              end
            end else begin
              s_nxt.sdo = 1'b0; // R5
            end
          end
          if (sclk_fall) begin
            s_nxt.rx_sh = rx_new; // R1 R25
            ci.shift = (s_r.rx_word == 6'h00) ||
                       (is_register_write_cmd && s_r.rx_word >= 6'h02 && s_r.rx_word < in_len - 6'h01);
            if (s_r.rx_bit == wbits - 6'h01) begin
              s_nxt.rx_bit = 6'h00;
              if (s_r.rx_word != 6'h3f) begin
                s_nxt.rx_word = s_r.rx_word + 6'h01;
              end
              if (s_r.rx_word == 6'h00) begin
                s_nxt.cmd = rx_content; // R11
              end else if (s_r.rx_word == 6'h01) begin
                s_nxt.cmd_ok = (rx_content == ci.value); // R11
                ci.seed = 1'b1; // R23
              end else if (is_register_write_cmd && s_r.rx_word < in_len - 6'h01) begin
                s_nxt.wr_buf[3'(s_r.rx_word - 6'h02)] = rx_content; // R13
              end else if (is_register_write_cmd && s_r.rx_word == in_len - 6'h01) begin
                s_nxt.data_ok = (rx_content == ci.value);
              end
            end else begin
              s_nxt.rx_bit = s_r.rx_bit + 6'h01;
            end
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    s_nxt.dev_lat_n = s_nxt.dev_lat_n & dev_fault_n; // R20
    done_sel = s_r.setup[SETUP_RDY_SRC_BIT] ?
      (s_r.setup[SETUP_EN_CUR_B_BIT] ? cur_b_done : s_r.setup[SETUP_EN_VOLT_B_BIT] && volt_b_done) :
      (s_r.setup[SETUP_EN_CUR_A_BIT] ? cur_a_done : s_r.setup[SETUP_EN_VOLT_A_BIT] && volt_a_done);
    if (cs_fall) begin
      s_nxt.drdy_n = 1'b1;
    end
    if (!s_r.ready) begin
      s_nxt.drdy_n = 1'b1; // R8
      s_nxt.ready = s_nxt.ready | 1'b1;
      if (s_nxt.cmd_resp == RESP_RESET && cs_rise) begin
        s_nxt.ready = 1'b0;
      end
    end else if (s_r.relow) begin
      s_nxt.drdy_n = 1'b0; // R6
      s_nxt.relow = 1'b0;
    end else if (done_sel) begin
      s_nxt.drdy_n = !s_r.drdy_n; // R6 R7
      s_nxt.relow = !s_r.drdy_n;
    end
    if (!s_nxt.ready) begin
      s_nxt.drdy_n = 1'b0; // R8
    end
    if (!reset_n) begin
      s_nxt = '0;
      s_nxt.st = ST_IDLE;
      s_nxt.cs_d = 1'b1;
      s_nxt.setup = SETUP_RESET;
      s_nxt.oe_n = 1'b1; // R2
      s_nxt.f_crc_n = 1'b1;
      s_nxt.f_to_n = 1'b1;
      s_nxt.f_cnt_n = 1'b1;
      s_nxt.f_acc_n = 1'b1;
      s_nxt.dev_lat_n = 3'h7;
      s_nxt.cmd_resp = RESP_NULL;
    end
  end

  always_ff @(posedge core_clk) begin
    s_r <= s_nxt;
  end

  assign sdo_out = s_r.sdo;
  assign sdo_oe_n = s_r.oe_n;
  assign data_ready_flag_n = s_r.drdy_n;
  assign reg_rdata = s_r.rd_data;
  assign conv_start_a = s_r.start_a;
  assign conv_start_b = s_r.start_b;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_frame_open;
    cs_fall;
  endsequence
  sequence seq_driven_low;
    !sdo_oe_n && !sdo_out;
  endsequence

  a_idle_released: assert property (s_r.st == ST_IDLE && !cs_fall |=> sdo_oe_n) // R2
    else $error("data output driven outside a frame");
  a_rise_resets: assert property (cs_rise |=> s_r.st == ST_IDLE && s_r.rx_word == 6'h00
    && s_r.tx_word == 6'h00 && s_r.rx_bit == 6'h00) // R3
    else $error("select rise did not reset the interface");
  a_fall_drives_low: assert property (seq_frame_open |=> seq_driven_low) // R4
    else $error("select fall did not drive output low");
  a_extra_clk_low: assert property (sclk_rise && s_r.tx_word >= frame_len |=> !sdo_out) // R5
    else $error("extra clock did not drive output low");
  a_hold_last: assert property (s_r.st == ST_FRAME && !sclk_rise && !cs_rise
    |=> $stable(sdo_out)) // R5
    else $error("output changed without a rising clock");
  a_ready_fall: assert property (s_r.ready && !s_r.relow && done_sel && data_ready_flag_n
    && !cs_rise |=> !data_ready_flag_n) // R6
    else $error("ready flag did not fall on new result");
  a_ready_boot: assert property (!s_r.ready |-> !data_ready_flag_n ##1 data_ready_flag_n) // R8
    else $error("ready flag not released after reset");
  a_start_pair: assert property (reg_wr && reg_addr == ADDR_CONV_CTRL && reg_wdata[1:0] == 2'h3
    |=> conv_start_a && conv_start_b) // R9
    else $error("converters not started together");
  a_flags_clear: assert property (seq_frame_open |=> s_r.f_crc_n && s_r.f_cnt_n
    && s_r.snap_status[23] == $past(s_r.f_crc_n)) // R18
    else $error("link flags not reported then cleared");
  a_fault_latch: assert property (!s_r.dev_lat_n[0] && !(reg_wr && reg_addr == ADDR_FAULT_CLR)
    && !cs_rise |=> !s_r.dev_lat_n[0]) // R20
    else $error("device fault flag released without a clear");
endmodule

/* verification/spi_host_model.sv */
`timescale 1ns/10ps
// ************************************************************
// Host controller model, mode 1, 24-bit words
// ************************************************************
module spi_host_model (
  // Serial pins
  output logic sclk_pin,
  output logic chip_select_low,
  output logic sdi_pin,
  input wire logic sdo_out,
  input wire logic sdo_oe_n
);
  logic last_r;
  logic [1:0] opened;
  wire sdo_line = sdo_oe_n ? ~last_r : sdo_out;
  initial begin
    sclk_pin = 1'b0;
    chip_select_low = 1'b1;
    sdi_pin = 1'b0;
    last_r = 1'b0;
    opened = 2'h3;
  end
  task automatic frame(input int nw, input logic [31:0] din[8], output logic [31:0] dout[8]);
    dout = '{default: 32'h0};
    chip_select_low = 1'b0;
    #200 opened = {sdo_oe_n, sdo_out};
    for (int w = 0; w < nw; w++) begin
      for (int b = 23; b >= 0; b--) begin
        sclk_pin = 1'b1;
        sdi_pin = din[w][b];
        #40 sclk_pin = 1'b0;
        dout[w][b] = sdo_line;
        last_r = sdo_line;
        #40;
      end
    end
    chip_select_low = 1'b1;
    sdi_pin = ~sdi_pin;
    #200;
  endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench import spi_frame_pkg::*;;
  logic core_clk, reset_n, sclk_pin, chip_select_low, sdi_pin, sdo_out, sdo_oe_n;
  logic data_ready_flag_n, reg_wr, reg_rd, conv_start_a, conv_start_b;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic [3:0] done;
  logic [23:0] da [4];
  logic [2:0] dev_fault_n;
  logic [1:0] starts;
  logic [31:0] o [8];
  int num_errors, n_compared, cnt_a;
  spi_frame_peripheral_interface #(.TIMEOUT_CYCLES(64)) spi_frame_peripheral_interface_i (
    .core_clk(core_clk), .reset_n(reset_n), .sclk_pin(sclk_pin),
    .chip_select_low(chip_select_low), .sdi_pin(sdi_pin), .sdo_out(sdo_out),
    .sdo_oe_n(sdo_oe_n), .data_ready_flag_n(data_ready_flag_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cur_a_done(done[0]), .cur_b_done(done[1]), .volt_a_done(done[2]),
    .volt_b_done(done[3]), .cur_a_data(da[0]), .cur_b_data(da[1]), .volt_a_data(da[2]),
    .volt_b_data(da[3]), .conv_start_a(conv_start_a), .conv_start_b(conv_start_b),
    .dev_fault_n(dev_fault_n));
  spi_host_model spi_host_model_i (.sclk_pin(sclk_pin), .chip_select_low(chip_select_low),
    .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (conv_start_a || conv_start_b) starts <= {conv_start_a, conv_start_b};
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] crc(input logic [31:0] w[8], input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < n; i++)
      for (int b = 23; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic run_frame(input int nw, input logic [15:0] cmd, input logic bad);
    logic [31:0] i [8];
    i = '{default: 32'h0};
    i[0] = {8'h00, cmd, 8'h00};
    i[1] = {8'h00, crc(i, 1) ^ {15'h0, bad}, 8'h00};
    spi_host_model_i.frame(nw, i, o);
    @(posedge core_clk);
  endtask
  task automatic pulse(input int k, input logic exp);
    done <= 4'h1 << k;
    if (k == 0) cnt_a++;
    @(posedge core_clk) done <= 4'h0;
    @(posedge core_clk) #1 check(data_ready_flag_n, exp);
    @(posedge core_clk);
  endtask
  task automatic test_regs;
    reg_read(ADDR_SETUP, rd);
    check(rd, 16'h003c);
    reg_read(8'h7f, rd);
    check(rd, 16'h0000);
    reg_write(ADDR_CONV_CTRL, 16'h0003);
    repeat (3) @(posedge core_clk);
    check(starts, 2'b11);
    dev_fault_n <= 3'b110;
    repeat (3) @(posedge core_clk) dev_fault_n <= 3'b111;
    repeat (3) @(posedge core_clk);
    reg_read(ADDR_STATUS_UP, rd);
    check(rd[10:8], 3'b110);
    reg_write(ADDR_FAULT_CLR, 16'h0001);
    reg_read(ADDR_STATUS_UP, rd);
    check(rd[10:8], 3'b111);
  endtask
  task automatic test_ready;
    pulse(1, 1'b1);
    pulse(0, 1'b0);
    run_frame(6, 16'h0000, 1'b0);
    check(data_ready_flag_n, 1'b1);
    reg_write(ADDR_SETUP, 16'h003e);
    pulse(0, 1'b1);
    pulse(1, 1'b0);
    run_frame(6, 16'h0000, 1'b0);
    reg_write(ADDR_SETUP, 16'h0038);
    pulse(2, 1'b0);
  endtask
  task automatic test_frames;
    run_frame(6, 16'h0000, 1'b0);
    check(spi_host_model_i.opened, 2'b00);
    check(sdo_oe_n, 1'b1);
    check(o[0][7:4], RESP_NULL);
    check(o[0][15:12], cnt_a[3:0]);
    for (int k = 0; k < 4; k++) check(o[k + 1], {8'h00, da[k]});
    check(o[5], {8'h00, crc(o, 5), 8'h00});
    run_frame(6, 16'h0000, 1'b1);
    run_frame(6, CMD_LOCK, 1'b0);
    check({o[0][23], o[0][7:4]}, {1'b0, RESP_NULL});
    run_frame(2, CMD_UNLOCK, 1'b0);
    check({o[0][23], o[0][7:4]}, {1'b1, RESP_LOCK});
    run_frame(6, CMD_UNLOCK, 1'b0);
    check({o[0][21], o[0][7:4]}, {1'b0, RESP_NULL});
    run_frame(6, 16'h0000, 1'b0);
    check({o[0][21], o[0][7:4]}, {1'b1, RESP_UNLOCK});
    run_frame(6, CMD_RESET, 1'b0);
    reg_read(ADDR_SETUP, rd);
    check(rd, SETUP_RESET);
    run_frame(6, {OP_REGISTER_READ_CMD, ADDR_SETUP, 5'h00}, 1'b0);
    check(o[0][7:4], RESP_RESET);
    run_frame(3, 16'h0000, 1'b0);
    check(o[0][7:4], RESP_REGISTER_READ_CMD);
    check(o[1], {8'h00, SETUP_RESET, ADDR_SETUP});
    check(o[2], {8'h00, crc(o, 2), 8'h00});
  endtask
  initial begin
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
    done = 4'h0; dev_fault_n = 3'b111; num_errors = 0; n_compared = 0;
    cnt_a = 0; da = '{24'h123456, 24'h89abcd, 24'h5a0f3c, 24'hc3e1a5};
    repeat (3) @(posedge core_clk);
    #1 check(data_ready_flag_n, 1'b0);
    @(posedge core_clk) reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(data_ready_flag_n, 1'b1);
    test_regs;
    test_ready;
    test_frames;
    print_verdict;
  end
  initial begin
    #400000 num_errors++;
    print_verdict;
  end
endmodule
